// ### rtl/jtag_prog_cfg.svh
// Constants for the flash programming test port.
// Assumes a 25 MHz system clock and a TCK sampled by that clock.
`ifndef JTAG_PROG_CFG_SVH
`define JTAG_PROG_CFG_SVH

// ==========================================================
// Widths
`define IR_W        4
`define KEY_W       16
`define CMD_W       15
`define BYTE_W      8
`define PC_W        16

// ==========================================================
// Opcodes
`define OP_RESET    4'hc
`define OP_KEY      4'h4
`define OP_CMD      4'h5
`define OP_FILL     4'h6
`define OP_FETCH    4'h7
`define OP_BYPASS   4'hf
`define IR_CAPTURE  4'h1

// ==========================================================
// Key and reset values
`define KEY_VALUE   16'ha370
`define KEY_RESET   16'h0000

// ==========================================================
// Command fields
`define CMD_OP_MSB  14
`define CMD_OP_LSB  8
`define CMD_ADDR_HI 7'h07
`define CMD_ADDR_LO 7'h03

// ==========================================================
// Timing
`define CLK_PERIOD_NS   40
`define RST_TIMEOUT_NS  4000
`define RST_TIMEOUT_CYC \
  ((`RST_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TAP_CLR_CLKS    2

`endif

// ### rtl/jtag_prog_pkg.sv
// Types for the flash programming test port.
// Assumes jtag_prog_cfg.svh holds the numeric constants.
package jtag_prog_pkg;

  // ========================================================
  // TAP controller states
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PDR   = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PIR   = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } tap_state_e;

  // ========================================================
  // Page buffer write word
  typedef struct packed {
    logic [15:0] addr;
    logic        high;
    logic [7:0]  data;
  } fill_word_s;

endpackage

// ### rtl/two_entry_buffer.sv
// Two-entry buffer for page buffer write words.
// Assumes both sides on clk; outReady may stall at any time.
`timescale 1ns/1ps
module two_entry_buffer (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  // Fill side
  input  wire logic                    inValid,
  output logic                         inReady,
  input  wire jtag_prog_pkg::fill_word_s inWord,
  // Drain side
  output logic                         outValid,
  input  wire logic                    outReady,
  output jtag_prog_pkg::fill_word_s    outWord
);
  import jtag_prog_pkg::*;

  fill_word_s mem [2];
  fill_word_s next_mem [2];
  logic       wrPtr, next_wrPtr;
  logic       rdPtr, next_rdPtr;
  logic [1:0] count, next_count;
  logic       push, pop;

  // ========================================================
  // Handshakes
  assign inReady  = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outWord  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    next_mem   = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push) begin
      next_mem[wrPtr] = inWord;
      next_wrPtr      = ~wrPtr;
    end
    if (pop) begin
      next_rdPtr = ~rdPtr;
    end
    if (push && !pop) begin
      next_count = count + 2'd1;
    end else if (pop && !push) begin
      next_count = count - 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wrPtr  <= 1'b0;
      rdPtr  <= 1'b0;
      count  <= 2'd0;
    end else if (ce) begin
      mem   <= next_mem;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

endmodule

// ### rtl/jtag_flash_programming_port.sv
// Flash programming logic behind the test access port.
// Assumes TAP pins come from outside the clk domain and flash
// result and read data come from logic on clk.
// Contract
// - All shift registers move LSB first
// - Instruction register is four bits wide
// - Reset chain opcode holds core reset unlatched
// - Reset chain leaves the TAP untouched
// - Key register match on update enters programming
// - Command capture loads previous command result
// - Command shift outputs result, inputs command
// - Update applies command, idle executes once
// - Page fill uses low command byte register
// - Fill update buffers byte for page write
// - Fill writes alternate low then high
// - Counter pre-increments before later low fills
// - Page fetch captures alternating low/high bytes
// - Counter post-increments after every high fetch
// - Port works only with fuse, no disable
// - Reset low clears disable bit after two
// - Only four TAP pins are needed
// - Key value is binary 1010001101110000
// - Key register clears at power-on reset
// - Core reset lasts timeout after chain release
`timescale 1ns/1ps
`include "jtag_prog_cfg.svh"
module jtag_flash_programming_port (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // TAP pins
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdoEn,
  // Port enable and core control
  input  wire logic                      tapAllowFuse,
  input  wire logic                      tapDisableBit,
  input  wire logic                      extRstn,
  output logic                           clearTapDisable,
  output logic                           coreResetHold,
  // Flash control
  output logic [14:0]                    flashCmd,
  output logic                           flashCmdApply,
  output logic                           flashExec,
  input  wire logic [14:0]               flashResult,
  output logic [15:0]                    pcAddr,
  input  wire logic [15:0]               flashRdData,
  // Page buffer writes
  output logic                           fillValid,
  input  wire logic                      fillReady,
  output jtag_prog_pkg::fill_word_s      fillWord
);
  import jtag_prog_pkg::*;

  // ========================================================
  // Pin synchronisers
  logic [1:0] tckSync, tmsSync, tdiSync;
  logic [1:0] fuseSync, disSync, extSync;
  logic       tckPrev, tckRise, tckFall, portOn;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tckSync  <= 2'b00;
      tmsSync  <= 2'b11;
      tdiSync  <= 2'b00;
      fuseSync <= 2'b00;
      disSync  <= 2'b00;
      extSync  <= 2'b11;
      tckPrev  <= 1'b0;
    end else if (ce) begin
      tckSync  <= {tckSync[0], tck};
      tmsSync  <= {tmsSync[0], tms};
      tdiSync  <= {tdiSync[0], tdi};
      fuseSync <= {fuseSync[0], tapAllowFuse};
      disSync  <= {disSync[0], tapDisableBit};
      extSync  <= {extSync[0], extRstn};
      tckPrev  <= tckSync[1];
    end
  end

  // Only TCK, TMS, TDI and TDO drive programming
  assign tckRise = tckSync[1] && !tckPrev;
  assign tckFall = !tckSync[1] && tckPrev;
  assign portOn  = fuseSync[1] && !disSync[1];

  // ========================================================
  // TAP next state
  function automatic tap_state_e tapNext(tap_state_e s, logic m);
    case (s)
      ST_TLR:   tapNext = m ? ST_TLR   : ST_RTI;
      ST_RTI:   tapNext = m ? ST_SELDR : ST_RTI;
      ST_SELDR: tapNext = m ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: tapNext = m ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  tapNext = m ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: tapNext = m ? ST_UPDR  : ST_PDR;
      ST_PDR:   tapNext = m ? ST_EX2DR : ST_PDR;
      ST_EX2DR: tapNext = m ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  tapNext = m ? ST_SELDR : ST_RTI;
      ST_SELIR: tapNext = m ? ST_TLR   : ST_CAPIR;
      ST_CAPIR: tapNext = m ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  tapNext = m ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: tapNext = m ? ST_UPIR  : ST_PIR;
      ST_PIR:   tapNext = m ? ST_EX2IR : ST_PIR;
      ST_EX2IR: tapNext = m ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  tapNext = m ? ST_SELDR : ST_RTI;
      default:  tapNext = ST_TLR;
    endcase
  endfunction

  // ========================================================
  // Programming state
  tap_state_e  state, next_state;
  logic [3:0]  irShift, next_irShift, instr, next_instr;
  logic        resetChain, next_resetChain, bypassBit, next_bypassBit;
  logic [15:0] key, next_key;
  logic [14:0] cmdShift, next_cmdShift, next_flashCmd;
  logic        progMode, next_progMode;
  logic        armExec, next_armExec;
  logic        next_flashCmdApply, next_flashExec;
  logic [15:0] next_pcAddr;
  logic        fillHigh, next_fillHigh, fillFirst, next_fillFirst;
  logic        fetchHigh, next_fetchHigh;
  logic        pending, next_pending, fillSet, bufReady;
  fill_word_s  pendWord, next_pendWord;
  logic        next_tdo, next_tdoEn;
  logic [7:0]  rstCnt, next_rstCnt;
  logic [1:0]  clrCnt, next_clrCnt;
  logic        next_coreResetHold, next_clearTapDisable;

  always_comb begin
    next_state         = state;
    next_irShift       = irShift;
    next_instr         = instr;
    next_resetChain    = resetChain;
    next_bypassBit     = bypassBit;
    next_key           = key;
    next_cmdShift      = cmdShift;
    next_flashCmd      = flashCmd;
    next_progMode      = progMode;
    next_armExec       = armExec;
    next_flashCmdApply = 1'b0;
    next_flashExec     = 1'b0;
    next_pcAddr        = pcAddr;
    next_fillHigh      = fillHigh;
    next_fillFirst     = fillFirst;
    next_fetchHigh     = fetchHigh;
    next_pending       = pending && !bufReady;
    next_pendWord      = pendWord;
    fillSet            = 1'b0;
    next_tdo           = tdo;
    next_tdoEn         = tdoEn;
    if (!portOn) begin
      next_state      = ST_TLR;
      next_instr      = `OP_BYPASS;
      next_resetChain = 1'b0;
      next_progMode   = 1'b0;
      next_tdoEn      = 1'b0;
    end else if (tckRise) begin
      // TAP state does not see the core reset
      next_state = tapNext(state, tmsSync[1]);
      case (state)
        ST_TLR: begin
          next_instr = `OP_BYPASS;
        end
        ST_RTI: begin
          if (armExec) begin
            next_flashExec = 1'b1;
            next_armExec   = 1'b0;
          end
        end
        ST_CAPIR: begin
          next_irShift = `IR_CAPTURE;
        end
        ST_SHIR: begin
          next_irShift = {tdiSync[1], irShift[3:1]};
        end
        ST_UPIR: begin
          next_instr     = irShift;
          next_fillHigh  = 1'b0;
          next_fillFirst = 1'b1;
          next_fetchHigh = 1'b0;
        end
        ST_CAPDR: begin
          next_bypassBit = 1'b0;
          if (instr == `OP_CMD) begin
            next_cmdShift = flashResult;
          end else if (instr == `OP_FETCH && progMode) begin
            next_cmdShift[7:0] = fetchHigh ? flashRdData[15:8]
                                           : flashRdData[7:0];
            next_fetchHigh = !fetchHigh;
            if (fetchHigh) begin
              next_pcAddr = pcAddr + 16'd1;
            end
          end
        end
        ST_SHDR: begin
          // Each data path shifts toward TDO from the top
          if (instr == `OP_RESET) begin
            next_resetChain = tdiSync[1];
          end else if (instr == `OP_KEY) begin
            next_key = {tdiSync[1], key[15:1]};
          end else if (instr == `OP_CMD) begin
            next_cmdShift = {tdiSync[1], cmdShift[14:1]};
          end else if (instr == `OP_FILL || instr == `OP_FETCH) begin
            next_cmdShift[7:0] = {tdiSync[1], cmdShift[7:1]};
          end else begin
            next_bypassBit = tdiSync[1];
          end
        end
        ST_UPDR: begin
          if (instr == `OP_KEY) begin
            next_progMode = (key == `KEY_VALUE);
          end else if (instr == `OP_CMD && progMode) begin
            next_flashCmd      = cmdShift;
            next_flashCmdApply = 1'b1;
            next_armExec       = 1'b1;
            if (cmdShift[`CMD_OP_MSB:`CMD_OP_LSB] == `CMD_ADDR_HI) begin
              next_pcAddr[15:8] = cmdShift[7:0];
            end else if (cmdShift[`CMD_OP_MSB:`CMD_OP_LSB]
                         == `CMD_ADDR_LO) begin
              next_pcAddr[7:0] = cmdShift[7:0];
            end
          end else if (instr == `OP_FILL && progMode) begin
            if (!fillHigh && !fillFirst) begin
              next_pcAddr = pcAddr + 16'd1;
            end
            fillSet             = 1'b1;
            next_pending        = 1'b1;
            next_pendWord.addr  = next_pcAddr;
            next_pendWord.high  = fillHigh;
            next_pendWord.data  = cmdShift[7:0];
            next_fillHigh       = !fillHigh;
            next_fillFirst      = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end else if (tckFall) begin
      next_tdoEn = (state == ST_SHDR) || (state == ST_SHIR);
      if (state == ST_SHIR) begin
        next_tdo = irShift[0];
      end else if (state == ST_SHDR) begin
        if (instr == `OP_RESET) begin
          next_tdo = resetChain;
        end else if (instr == `OP_KEY) begin
          next_tdo = key[0];
        end else if (instr == `OP_CMD || instr == `OP_FILL
                     || instr == `OP_FETCH) begin
          next_tdo = cmdShift[0];
        end else begin
          next_tdo = bypassBit;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state         <= ST_TLR;
      irShift       <= `IR_CAPTURE;
      instr         <= `OP_BYPASS;
      resetChain    <= 1'b0;
      bypassBit     <= 1'b0;
      key           <= `KEY_RESET;
      cmdShift      <= '0;
      flashCmd      <= '0;
      progMode      <= 1'b0;
      armExec       <= 1'b0;
      flashCmdApply <= 1'b0;
      flashExec     <= 1'b0;
      pcAddr        <= '0;
      fillHigh      <= 1'b0;
      fillFirst     <= 1'b1;
      fetchHigh     <= 1'b0;
      pending       <= 1'b0;
      pendWord      <= '0;
      tdo           <= 1'b0;
      tdoEn         <= 1'b0;
    end else if (ce) begin
      state         <= next_state;
      irShift       <= next_irShift;
      instr         <= next_instr;
      resetChain    <= next_resetChain;
      bypassBit     <= next_bypassBit;
      key           <= next_key;
      cmdShift      <= next_cmdShift;
      flashCmd      <= next_flashCmd;
      progMode      <= next_progMode;
      armExec       <= next_armExec;
      flashCmdApply <= next_flashCmdApply;
      flashExec     <= next_flashExec;
      pcAddr        <= next_pcAddr;
      fillHigh      <= next_fillHigh;
      fillFirst     <= next_fillFirst;
      fetchHigh     <= next_fetchHigh;
      pending       <= next_pending;
      pendWord      <= next_pendWord;
      tdo           <= next_tdo;
      tdoEn         <= next_tdoEn;
    end
  end

  // ========================================================
  // Core reset hold and disable-bit clear
  always_comb begin
    next_rstCnt          = rstCnt;
    next_clrCnt          = clrCnt;
    next_clearTapDisable = 1'b0;
    if (resetChain) begin
      next_rstCnt = 8'(`RST_TIMEOUT_CYC);
    end else if (rstCnt != 8'd0) begin
      next_rstCnt = rstCnt - 8'd1;
    end
    next_coreResetHold = resetChain || (rstCnt > 8'd1);
    if (disSync[1] && !extSync[1]) begin
      if (clrCnt == 2'(`TAP_CLR_CLKS - 1)) begin
        next_clearTapDisable = 1'b1;
        next_clrCnt          = 2'd0;
      end else begin
        next_clrCnt = clrCnt + 2'd1;
      end
    end else begin
      next_clrCnt = 2'd0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstCnt          <= 8'd0;
      clrCnt          <= 2'd0;
      coreResetHold   <= 1'b0;
      clearTapDisable <= 1'b0;
    end else if (ce) begin
      rstCnt          <= next_rstCnt;
      clrCnt          <= next_clrCnt;
      coreResetHold   <= next_coreResetHold;
      clearTapDisable <= next_clearTapDisable;
    end
  end

  // ========================================================
  // Page buffer write path
  two_entry_buffer fillBuf (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .inValid  (pending),
    .inReady  (bufReady),
    .inWord   (pendWord),
    .outValid (fillValid),
    .outReady (fillReady),
    .outWord  (fillWord)
  );

  // ========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  chk_key_entry: assert property (
    (portOn && tckRise && state == ST_UPDR && instr == `OP_KEY
     && key == `KEY_VALUE) |=> progMode)
    else $error("valid key did not enter programming");
  chk_exec_once: assert property (flashExec |=> !flashExec)
    else $error("execute pulse longer than one cycle");
  chk_fill_first: assert property (
    (fillSet && fillFirst) |=> (pendWord.high == 1'b0))
    else $error("first fill did not go to low byte");
  chk_fill_keyed: assert property (fillSet |-> progMode)
    else $error("fill without programming mode");
  chk_chain_hold: assert property (
    resetChain |=> coreResetHold)
    else $error("reset chain did not hold core");
  sequence chainRelease;
    resetChain ##1 !resetChain;
  endsequence
  chk_reset_tail: assert property (
    chainRelease |-> ##1 coreResetHold [*8])
    else $error("core reset ended before timeout");
  chk_port_gate: assert property (!portOn |=> state == ST_TLR)
    else $error("TAP active while port disabled");
  chk_ir_lsb: assert property (
    (portOn && tckRise && state == ST_SHIR) |=>
    irShift[3] == $past(tdiSync[1]))
    else $error("instruction shift not LSB first");
  chk_fetch_step: assert property (
    (portOn && tckRise && state == ST_CAPDR && instr == `OP_FETCH
     && progMode && fetchHigh) |=> pcAddr == $past(pcAddr) + 16'd1)
    else $error("counter not stepped after high fetch");
  chk_dis_clear: assert property (
    clearTapDisable |-> !$past(extSync[1], 2) && $past(disSync[1], 2))
    else $error("disable cleared without reset low");

endmodule

// ### tb/jtag_programmer_model.sv
// Programmer model that drives the four test access port pins.
// Assumes clk is the 25 MHz bench clock; one TCK period is 8 clk.
`timescale 1ns/1ps
module jtag_programmer_model (
  // Clock
  input  wire logic clk,
  // TAP pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // ========================================================
  // Pins idle, TCK stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ========================================================
  // One TCK period: 4 clk low, 4 clk high, TDO read before fall
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    q = tdo;
    tck <= 1'b0;
  endtask

  // Rises in Run-Test/Idle
  task automatic idle(input int n);
    logic q;
    repeat (n) bit_cyc(1'b0, tdi, q);
  endtask

  // Scan n bits LSB first from idle and back; four pins only
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = '0;
    bit_cyc(1'b1, tdi, q);
    if (ir) bit_cyc(1'b1, tdi, q);
    bit_cyc(1'b0, tdi, q);
    bit_cyc(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_cyc(1'b1, tdi, q);
    bit_cyc(1'b0, tdi, q);
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the flash programming test port.
// Assumes the programmer model in tb and the design under rtl.
`timescale 1ns/1ps
`include "jtag_prog_cfg.svh"
module tb_top;
  import jtag_prog_pkg::*;
  logic        clk, rstn, ce, tck, tms, tdi, tdo, tdoEn, stall;
  logic        tapAllowFuse, tapDisableBit, extRstn, clearTapDisable;
  logic        coreResetHold, flashCmdApply, flashExec, fillValid;
  logic        fillReady;
  logic [14:0] flashCmd, flashResult;
  logic [15:0] pcAddr, flashRdData, cap;
  fill_word_s  fillWord;
  fill_word_s  words[$];
  int          n_fail, checks, nApply, nExec, nClear, nEn;

  jtag_flash_programming_port dut (.clk(clk), .rstn(rstn), .ce(ce),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
    .tapAllowFuse(tapAllowFuse), .tapDisableBit(tapDisableBit),
    .extRstn(extRstn), .clearTapDisable(clearTapDisable),
    .coreResetHold(coreResetHold), .flashCmd(flashCmd),
    .flashCmdApply(flashCmdApply), .flashExec(flashExec),
    .flashResult(flashResult), .pcAddr(pcAddr),
    .flashRdData(flashRdData), .fillValid(fillValid),
    .fillReady(fillReady), .fillWord(fillWord));
  jtag_programmer_model prog (.clk(clk), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));

  // ========================================================
  // Flash stand-in, clock, counters and stalling page buffer
  assign flashRdData = pcAddr ^ 16'hc35a;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (flashCmdApply === 1'b1) nApply++;
    if (flashExec === 1'b1) nExec++;
    if (tdoEn === 1'b1) nEn++;
    if (clearTapDisable === 1'b1) begin
      nClear++;
      tapDisableBit <= 1'b0;
    end
    if (fillValid === 1'b1 && fillReady === 1'b1) words.push_back(fillWord);
    fillReady <= !stall && !fillReady;
  end

  // ========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ir(input logic [3:0] op);
    prog.scan(1'b1, 4, {12'h000, op}, cap);
    @(negedge clk);
    check(cap[3:0], `IR_CAPTURE);
  endtask

  task automatic dr(input int n, input logic [15:0] v);
    prog.scan(1'b0, n, v, cap);
    @(negedge clk);
  endtask

  task automatic rest(input int n);
    prog.idle(n);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_nokey;
    ir(`OP_CMD);
    dr(15, 16'h0712);
    check(cap[14:0], 15'h2b3c);
    ir(`OP_FILL);
    dr(8, 16'h0099);
    rest(11);
    check(nApply, 0);
    check(words.size(), 0);
    $display("t_nokey done");
  endtask

  task automatic t_key;
    int e0;
    ir(`OP_KEY);
    dr(16, `KEY_VALUE ^ 16'h0001);
    ir(`OP_CMD);
    dr(15, 16'h0712);
    check(nApply, 0);
    ir(`OP_KEY);
    dr(16, `KEY_VALUE);
    @(posedge clk) flashResult <= 15'h4d21;
    ir(`OP_CMD);
    e0 = nExec;
    dr(15, 16'h0712);
    check(cap[14:0], 15'h4d21);
    check(nApply, 1);
    check(flashCmd, 15'h0712);
    rest(3);
    check(nExec - e0, 1);
    dr(15, 16'h0334);
    rest(1);
    check(pcAddr, 16'h1234);
    $display("t_key done");
  endtask

  task automatic t_fill;
    stall = 1'b1;
    ir(`OP_FILL);
    for (int i = 0; i < 3; i++) dr(8, 16'h0011 * (i + 1));
    rest(11);
    check(fillValid, 1);
    check(words.size(), 0);
    stall = 1'b0;
    dr(8, 16'h0044);
    rest(11);
    check(words.size(), 4);
    for (int i = 0; i < 4; i++)
      check(words[i], {16'(16'h1234 + i / 2), i[0],
                       8'(8'h11 * (i + 1))});
    check(pcAddr, 16'h1235);
    $display("t_fill done");
  endtask

  task automatic t_fetch;
    logic [15:0] e;
    ir(`OP_FETCH);
    for (int i = 0; i < 3; i++) begin
      dr(8, 16'h0000);
      e = 16'((16'h1235 + i / 2) ^ 16'hc35a);
      check(cap[7:0], i[0] ? e[15:8] : e[7:0]);
    end
    check(pcAddr, 16'h1236);
    ir(`OP_BYPASS);
    dr(16, 16'hffff);
    check(pcAddr, 16'h1236);
    check(words.size(), 4);
    $display("t_fetch done");
  endtask

  task automatic t_chain;
    ir(`OP_RESET);
    dr(1, 16'h0001);
    check(coreResetHold, 1);
    ir(`OP_RESET);
    dr(1, 16'h0000);
    repeat (10) @(negedge clk);
    check(coreResetHold, 1);
    @(posedge clk) ce <= 1'b0;
    repeat (150) @(negedge clk);
    check(coreResetHold, 1);
    @(posedge clk) ce <= 1'b1;
    repeat (150) @(negedge clk);
    check(coreResetHold, 0);
    $display("t_chain done");
  endtask

  task automatic t_off;
    ir(`OP_KEY);
    dr(16, 16'h0000);
    @(posedge clk) tapDisableBit <= 1'b1;
    nEn = 0;
    prog.scan(1'b1, 4, 16'h0005, cap);
    @(negedge clk);
    check(nEn, 0);
    // Pins reclaimed by reset for programming only
    @(posedge clk) extRstn <= 1'b0;
    repeat (8) @(negedge clk);
    check(nClear > 0, 1);
    check(tapDisableBit, 0);
    @(posedge clk) extRstn <= 1'b1;
    rest(1);
    ir(`OP_CMD);
    dr(15, 16'h0712);
    check(nApply, 2);
    @(posedge clk) tapAllowFuse <= 1'b0;
    nEn = 0;
    prog.scan(1'b1, 4, 16'h0005, cap);
    @(negedge clk);
    check(nEn, 0);
    $display("t_off done");
  endtask

  // ========================================================
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    stall = 1'b0;
    fillReady = 1'b0;
    extRstn = 1'b1;
    tapAllowFuse = 1'b1;
    tapDisableBit = 1'b0;
    flashResult = 15'h2b3c;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rest(1);
    t_nokey();
    t_key();
    t_fill();
    t_fetch();
    t_chain();
    t_off();
    wrap_up();
  end

  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
endmodule
